// File: bfpl_pkg.sv
// Package with shared constants and types for the buck fault protection logic.
package bfpl_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS     = 4000;
  localparam int unsigned PG_FILTER_NS      = 3000;
  localparam int unsigned PG_FILTER_CYCLES  = (PG_FILTER_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned ISAMPLE_DELAY_NS  = 400;
  localparam int unsigned ISAMPLE_CYCLES    =
    (ISAMPLE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ------------------------------------------------------------------
  // Overcurrent sequence, in switching cycles
  // ------------------------------------------------------------------
  localparam logic [4:0] OC_SKIP_WINDOW  = 5'h08;
  localparam logic [4:0] OC_TOTAL_WINDOW = 5'h10;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic PG_GOOD_RESET = 1'b0;
  localparam logic LATCH_RESET   = 1'b0;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    BFPL_OC_IDLE,
    BFPL_OC_SKIP,
    BFPL_OC_WATCH,
    BFPL_OC_LATCHED
  } bfpl_oc_state_t;

  // Comparator flags from one channel's analog front end.
  typedef struct packed {
    logic softstart_done;
    logic window_ok;
    logic undervoltage;
    logic overvoltage;
    logic overcurrent_trip;
  } bfpl_cmp_t;

  // Gate drive pair for one channel.
  typedef struct packed {
    logic upper_gate_drive;
    logic lower_gate_drive;
  } bfpl_gate_t;

endpackage

// File: bfpl_channel.sv
// One channel of fault supervision: filtering, overcurrent sequencing and gate override.
`timescale 1ns/1ns
`default_nettype none

module bfpl_channel #(
  parameter int unsigned PG_FILTER = bfpl_pkg::PG_FILTER_CYCLES,
  parameter int unsigned SAMPLE_DL = bfpl_pkg::ISAMPLE_CYCLES
) (
  // Clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 reset_n_i,
  // Control
  input  wire logic                 clear_latch_i,
  input  wire logic                 protect_en_i,
  input  wire logic                 force_off_i,
  // Synchronized comparator flags and PWM
  input  wire bfpl_pkg::bfpl_cmp_t  cmp_i,
  input  wire logic                 pwm_i,
  // Outputs
  output var  bfpl_pkg::bfpl_gate_t gate_o,
  output logic                      good_o,
  output logic                      latched_o,
  output logic                      ov_o
);

  // ------------------------------------------------------------------
  // Switching cycle edge and current sample and hold
  // ------------------------------------------------------------------
  logic                  pwm_q;
  logic                  cycle_start;
  logic                  upper_fall;
  logic [8:0]            smp_cnt_q;
  logic                  smp_run_q;
  logic                  oc_held_q;
  logic                  uv_latch_q;
  logic                  ov_act;
  logic                  oc_latch;
  logic                  skip;
  bfpl_pkg::bfpl_oc_state_t oc_state_q;
  logic [4:0]            oc_cnt_q;
  logic [11:0]           pg_cnt_q;
  logic                  pg_raw;
  logic                  pg_q;

  assign cycle_start = pwm_i & ~pwm_q;
  assign upper_fall  = ~pwm_i & pwm_q;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= pwm_i;
    end
  end

  // Sample the comparator a fixed delay after the upper switch turns off.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      smp_cnt_q <= 9'h000;
      smp_run_q <= 1'b0;
      oc_held_q <= 1'b0;
    end else if (upper_fall) begin
      smp_cnt_q <= 9'h000;
      smp_run_q <= 1'b1;
    end else if (smp_run_q) begin
      if (smp_cnt_q == 9'(SAMPLE_DL - 1)) begin
        smp_run_q <= 1'b0;
        oc_held_q <= cmp_i.overcurrent_trip;
      end else begin
        smp_cnt_q <= smp_cnt_q + 9'h001;
      end
    end else if (oc_held_q && !cmp_i.overcurrent_trip) begin
      // Continuous monitoring releases the skip once current falls.
      oc_held_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Overcurrent sequence counted in switching cycles
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      oc_state_q <= bfpl_pkg::BFPL_OC_IDLE;
      oc_cnt_q   <= 5'h00;
    end else if (clear_latch_i) begin
      oc_state_q <= bfpl_pkg::BFPL_OC_IDLE;
      oc_cnt_q   <= 5'h00;
    end else if (!protect_en_i) begin
      oc_state_q <= bfpl_pkg::BFPL_OC_IDLE;
      oc_cnt_q   <= 5'h00;
    end else begin
      case (oc_state_q)
        bfpl_pkg::BFPL_OC_IDLE: begin
          if (oc_held_q) begin
            oc_state_q <= bfpl_pkg::BFPL_OC_SKIP;
            oc_cnt_q   <= 5'h00;
          end
        end
        bfpl_pkg::BFPL_OC_SKIP: begin
          if (cycle_start) begin
            oc_cnt_q <= oc_cnt_q + 5'h01;
            if (oc_cnt_q + 5'h01 == bfpl_pkg::OC_SKIP_WINDOW) begin
              oc_state_q <= bfpl_pkg::BFPL_OC_WATCH;
            end
          end
        end
        bfpl_pkg::BFPL_OC_WATCH: begin
          if (oc_held_q) begin
            oc_state_q <= bfpl_pkg::BFPL_OC_LATCHED;
          end else if (cycle_start) begin
            oc_cnt_q <= oc_cnt_q + 5'h01;
            if (oc_cnt_q + 5'h01 == bfpl_pkg::OC_TOTAL_WINDOW) begin
              oc_state_q <= bfpl_pkg::BFPL_OC_IDLE;
              oc_cnt_q   <= 5'h00;
            end
          end
        end
        default: begin
          oc_state_q <= bfpl_pkg::BFPL_OC_LATCHED;
        end
      endcase
    end
  end

  assign oc_latch = (oc_state_q == bfpl_pkg::BFPL_OC_LATCHED);

  // ------------------------------------------------------------------
  // Undervoltage latch, armed after soft-start
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      uv_latch_q <= bfpl_pkg::LATCH_RESET;
    end else if (protect_en_i && cmp_i.softstart_done && cmp_i.undervoltage) begin
      uv_latch_q <= 1'b1;
    end else if (clear_latch_i) begin
      uv_latch_q <= 1'b0;
    end
  end

  assign ov_act    = protect_en_i & cmp_i.overvoltage;
  assign latched_o = oc_latch | uv_latch_q;
  assign ov_o      = ov_act;
  assign skip      = oc_held_q & protect_en_i;

  // ------------------------------------------------------------------
  // Gate override
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gate_o <= '0;
    end else if (latched_o || force_off_i) begin
      gate_o <= '0;
    end else if (ov_act) begin
      gate_o.upper_gate_drive <= 1'b0;
      gate_o.lower_gate_drive <= 1'b1;
    end else begin
      gate_o.upper_gate_drive <= pwm_i & ~skip;
      gate_o.lower_gate_drive <= ~pwm_i;
    end
  end

  // ------------------------------------------------------------------
  // Power-good deglitch
  // ------------------------------------------------------------------
  assign pg_raw = cmp_i.softstart_done & cmp_i.window_ok;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pg_cnt_q <= 12'h000;
      pg_q     <= bfpl_pkg::PG_GOOD_RESET;
    end else if (pg_raw == pg_q) begin
      pg_cnt_q <= 12'h000;
    end else if (pg_cnt_q == 12'(PG_FILTER - 1)) begin
      pg_cnt_q <= 12'h000;
      pg_q     <= pg_raw;
    end else begin
      pg_cnt_q <= pg_cnt_q + 12'h001;
    end
  end

  assign good_o = pg_q & ~latched_o & ~ov_act & ~force_off_i;

endmodule

`default_nettype wire

// File: bfpl_top.sv
// Top level of the two-channel buck fault protection logic.
`timescale 1ns/1ns
`default_nettype none

module bfpl_top #(
  parameter int unsigned NUM_CH    = 2,
  parameter int unsigned PG_FILTER = bfpl_pkg::PG_FILTER_CYCLES,
  parameter int unsigned SAMPLE_DL = bfpl_pkg::ISAMPLE_CYCLES
) (
  // Clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 reset_n_i,
  // Enables and mode
  input  wire logic                 channel1_enable_i,
  input  wire logic                 channel2_enable_i,
  input  wire logic                 tracking_mode_i,
  // Analog comparator flags, asynchronous
  input  wire bfpl_pkg::bfpl_cmp_t  cmp_ch1_i,
  input  wire bfpl_pkg::bfpl_cmp_t  cmp_ch2_i,
  // PWM requests from the modulators
  input  wire logic                 pwm_ch1_i,
  input  wire logic                 pwm_ch2_i,
  // Gate drives
  output var  bfpl_pkg::bfpl_gate_t gate_ch1_o,
  output var  bfpl_pkg::bfpl_gate_t gate_ch2_o,
  // Open-drain power-good pins and reference buffer enable
  output logic                      power_good_out_o,
  output logic                      power_good_out_oe_o,
  output logic                      channel2_good_o,
  output logic                      channel2_good_oe_o,
  output logic                      reference_buffer_en_o,
  // Status
  output logic                      ch1_latched_o,
  output logic                      ch2_latched_o,
  output logic                      ch1_overvoltage_o,
  output logic                      ch2_overvoltage_o
);

  // ------------------------------------------------------------------
  // Input synchronizers
  // ------------------------------------------------------------------
  localparam int unsigned SW = $bits(bfpl_pkg::bfpl_cmp_t);

  logic [SW-1:0] c1_m_q;
  logic [SW-1:0] c1_s_q;
  logic [SW-1:0] c2_m_q;
  logic [SW-1:0] c2_s_q;
  logic [4:0]    ctl_m_q;
  logic [4:0]    ctl_s_q;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      c1_m_q  <= '0;
      c1_s_q  <= '0;
      c2_m_q  <= '0;
      c2_s_q  <= '0;
      ctl_m_q <= 5'h00;
      ctl_s_q <= 5'h00;
    end else begin
      c1_m_q  <= cmp_ch1_i;
      c1_s_q  <= c1_m_q;
      c2_m_q  <= cmp_ch2_i;
      c2_s_q  <= c2_m_q;
      ctl_m_q <= {pwm_ch2_i, pwm_ch1_i, tracking_mode_i,
                  channel2_enable_i, channel1_enable_i};
      ctl_s_q <= ctl_m_q;
    end
  end

  logic en1;
  logic en2;
  logic trk;
  logic pwm1;
  logic pwm2;
  logic clear_latch;
  logic ch2_prot;

  assign en1         = ctl_s_q[0];
  assign en2         = ctl_s_q[1];
  // Mode pin is assumed static, so a simple synchronized level suffices.
  assign trk         = ctl_s_q[2];
  assign pwm1        = ctl_s_q[3];
  assign pwm2        = ctl_s_q[4];
  assign clear_latch = ~en1 & ~en2;
  assign ch2_prot    = ~trk;

  // ------------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------------
  logic good1;
  logic good2;
  logic lat1;
  logic lat2;

  // A termination short shows up on channel one's own comparators.
  bfpl_channel #(
    .PG_FILTER (PG_FILTER),
    .SAMPLE_DL (SAMPLE_DL)
  ) u_ch1 (
    .clock_i       (clock_i),
    .reset_n_i     (reset_n_i),
    .clear_latch_i (clear_latch),
    .protect_en_i  (1'b1),
    .force_off_i   (~en1),
    .cmp_i         (bfpl_pkg::bfpl_cmp_t'(c1_s_q)),
    .pwm_i         (pwm1),
    .gate_o        (gate_ch1_o),
    .good_o        (good1),
    .latched_o     (lat1),
    .ov_o          (ch1_overvoltage_o)
  );

  bfpl_channel #(
    .PG_FILTER (PG_FILTER),
    .SAMPLE_DL (SAMPLE_DL)
  ) u_ch2 (
    .clock_i       (clock_i),
    .reset_n_i     (reset_n_i),
    .clear_latch_i (clear_latch),
    .protect_en_i  (ch2_prot),
    .force_off_i   (~en2),
    .cmp_i         (bfpl_pkg::bfpl_cmp_t'(c2_s_q)),
    .pwm_i         (pwm2),
    .gate_o        (gate_ch2_o),
    .good_o        (good2),
    .latched_o     (lat2),
    .ov_o          (ch2_overvoltage_o)
  );

  assign ch1_latched_o = lat1;
  assign ch2_latched_o = lat2;

  // ------------------------------------------------------------------
  // Open-drain power-good pins and reference buffer enable
  // ------------------------------------------------------------------
  // The pins only ever pull low; the output data is constant zero.
  assign power_good_out_o      = 1'b0;
  assign power_good_out_oe_o   = ~good1;
  assign channel2_good_o       = 1'b0;
  // In tracking mode the pin carries the reference buffer instead.
  assign channel2_good_oe_o    = ~good2 & ~trk;
  assign reference_buffer_en_o = trk;

endmodule

`default_nettype wire

// File: bfpl_top_props.sv
// Checker of the fault protection top level.
`timescale 1ns/1ns
`default_nettype none
module bfpl_top_props #(
  parameter int unsigned PG_FILTER = 8
) (
  // Clock, reset and inputs
  input wire logic                 clock_i,
  input wire logic                 reset_n_i,
  input wire logic                 channel1_enable_i,
  input wire logic                 channel2_enable_i,
  input wire bfpl_pkg::bfpl_cmp_t  cmp_ch1_i,
  // Outputs
  input wire bfpl_pkg::bfpl_gate_t gate_ch1_o,
  input wire logic                 power_good_out_o,
  input wire logic                 power_good_out_oe_o,
  input wire logic                 channel2_good_o,
  input wire logic                 channel2_good_oe_o,
  input wire logic                 reference_buffer_en_o,
  input wire logic                 ch1_latched_o,
  input wire logic                 ch2_latched_o,
  input wire logic                 ch1_overvoltage_o
);
  // ------------------------------------------------------------
  // Run lengths of a good window and of a bad window or unfinished soft start
  // ------------------------------------------------------------
  logic [7:0] win_cnt_q;
  logic [7:0] bad_cnt_q;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      win_cnt_q <= 8'h00;
      bad_cnt_q <= 8'h00;
    end else begin
      win_cnt_q <= !cmp_ch1_i.window_ok ? 8'h00 : win_cnt_q + {7'h00, win_cnt_q != 8'hff};
      bad_cnt_q <= (cmp_ch1_i.window_ok && cmp_ch1_i.softstart_done) ? 8'h00 :
                   bad_cnt_q + {7'h00, bad_cnt_q != 8'hff};
    end
  end
  a_good_filter: assert property ($fell(power_good_out_oe_o) |-> win_cnt_q >= PG_FILTER)
    else $error("good released before the window settled");
  a_good_drop: assert property (bad_cnt_q > PG_FILTER + 6 |-> power_good_out_oe_o)
    else $error("good kept while window or soft start is bad");
  a_od_data: assert property (power_good_out_o == 1'b0 && channel2_good_o == 1'b0)
    else $error("open drain pin driven high");
  a_ov_follow: assert property (ch1_overvoltage_o == $past(cmp_ch1_i.overvoltage, 2))
    else $error("clamp status does not follow its flag");
  a_ov_clamp: assert property (ch1_overvoltage_o [*2] ##0 !ch1_latched_o |->
    gate_ch1_o == 2'b01 && power_good_out_oe_o)
    else $error("clamp did not force lower gate");
  a_uv_latch: assert property ($rose(cmp_ch1_i.undervoltage) && cmp_ch1_i.softstart_done &&
    channel1_enable_i |-> ##[2:4] ch1_latched_o)
    else $error("undervoltage did not latch");
  a_latch_off: assert property (ch1_latched_o [*2] |->
    gate_ch1_o == 2'b00 && power_good_out_oe_o)
    else $error("latched channel still switching");
  a_latch_clear: assert property ($fell(ch1_latched_o) |->
    !$past(channel1_enable_i, 2) && !$past(channel2_enable_i, 2))
    else $error("latch cleared with an enable high");
  a_track_mode: assert property (reference_buffer_en_o |->
    !channel2_good_oe_o && !ch2_latched_o)
    else $error("second channel active in tracking mode");
  c_latch: cover property ($rose(ch1_latched_o));
  c_good: cover property ($fell(power_good_out_oe_o));
  c_clamp: cover property ($rose(ch1_overvoltage_o));
endmodule
bind bfpl_top bfpl_top_props #(.PG_FILTER(PG_FILTER)) u_props (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .channel1_enable_i(channel1_enable_i),
  .channel2_enable_i(channel2_enable_i), .cmp_ch1_i(cmp_ch1_i), .gate_ch1_o(gate_ch1_o),
  .power_good_out_o(power_good_out_o), .power_good_out_oe_o(power_good_out_oe_o),
  .channel2_good_o(channel2_good_o), .channel2_good_oe_o(channel2_good_oe_o),
  .reference_buffer_en_o(reference_buffer_en_o), .ch1_latched_o(ch1_latched_o),
  .ch2_latched_o(ch2_latched_o), .ch1_overvoltage_o(ch1_overvoltage_o)
);
`default_nettype wire

// File: bfpl_plant.sv
// Model of one power stage: modulator, soft start and comparators.
`timescale 1ns/1ns
`default_nettype none
module bfpl_plant (
  // Clock and reset
  input  wire logic               clock_i,
  input  wire logic               reset_n_i,
  // Enable and faults {window bad, under, over, overcurrent}
  input  wire logic               en_i,
  input  wire logic [3:0]         fault_i,
  // Modulator and comparators
  output logic                    pwm_o,
  output var bfpl_pkg::bfpl_cmp_t cmp_o
);
  logic [4:0] ph_q;
  logic [4:0] ss_q;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) ph_q <= 5'h00;
    else ph_q <= (ph_q == 5'h13) ? 5'h00 : ph_q + 5'h01;
  end
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) ss_q <= 5'h00;
    else if (!en_i) ss_q <= 5'h00;
    else if (ss_q != 5'h14) ss_q <= ss_q + 5'h01;
  end
  // One switching cycle is twenty clocks.
  assign pwm_o = ph_q < 5'h0a;
  // A skipped pulse leaves both switches off; the overcurrent flag follows fault_i, so an overload stays visible.
  assign cmp_o = {ss_q == 5'h14, !fault_i[3], fault_i[2], fault_i[1],
                  fault_i[0]};
endmodule
`default_nettype wire

// File: buck_fault_protection_logic_tb_top.sv
// Testbench of the fault protection top level.
`timescale 1ns/1ns
`default_nettype none
module buck_fault_protection_logic_tb_top;
  logic clock_i, reset_n_i, ena_a, ena_b, trk, pwm_a, pwm_b;
  logic pwr_a, pwr_a_oe, pwr_b, pwr_b_oe, ref_en, lat_a, lat_b, ovr_a, ovr_b;
  logic [3:0] f1, f2;
  logic [9:0] obs;
  logic [19:0] n;
  logic [19:0] note_q [$];
  bfpl_pkg::bfpl_cmp_t c1, c2;
  bfpl_pkg::bfpl_gate_t g1, g2;
  int error_cnt, total_checks, seed, cyc, len;
  localparam logic [9:0] M_G1 = 10'h300, M_P1 = 10'h020, M_P2 = 10'h010;
  localparam logic [9:0] M_L1 = 10'h008, M_L2 = 10'h004, M_O1 = 10'h002, M_R = 10'h001;
  localparam logic [9:0] M_G2 = 10'h0c0;
  assign obs = {g1, g2, pwr_a_oe, pwr_b_oe, lat_a, lat_b, ovr_a, ref_en};
  bfpl_plant u_pa (.clock_i(clock_i), .reset_n_i(reset_n_i), .en_i(ena_a), .fault_i(f1),
    .pwm_o(pwm_a), .cmp_o(c1));
  bfpl_plant u_pb (.clock_i(clock_i), .reset_n_i(reset_n_i), .en_i(ena_b), .fault_i(f2),
    .pwm_o(pwm_b), .cmp_o(c2));
  bfpl_top #(.PG_FILTER(8), .SAMPLE_DL(4)) u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .channel1_enable_i(ena_a), .channel2_enable_i(ena_b), .tracking_mode_i(trk),
    .cmp_ch1_i(c1), .cmp_ch2_i(c2), .pwm_ch1_i(pwm_a), .pwm_ch2_i(pwm_b),
    .gate_ch1_o(g1), .gate_ch2_o(g2), .power_good_out_o(pwr_a),
    .power_good_out_oe_o(pwr_a_oe), .channel2_good_o(pwr_b), .channel2_good_oe_o(pwr_b_oe),
    .reference_buffer_en_o(ref_en), .ch1_latched_o(lat_a), .ch2_latched_o(lat_b),
    .ch1_overvoltage_o(ovr_a), .ch2_overvoltage_o(ovr_b));
  // ------------------------------------------------------------
  // Shared tasks and the scoreboard
  // ------------------------------------------------------------
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic note(input logic [9:0] m, input logic [9:0] e);
    note_q.push_back({m, e});
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock_i);
  endtask
  task automatic per(input int k);
    repeat (k) @(posedge pwm_a);
    tick(7);
  endtask
  task automatic clear_both();
    ena_a <= 1'b0;
    ena_b <= 1'b0;
    tick(10);
    ena_a <= 1'b1;
    ena_b <= 1'b1;
    tick(30);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(negedge clock_i) begin
    if (note_q.size() > 0) begin
      n = note_q.pop_front();
      check(obs & n[19:10], n[9:0]);
    end
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {ena_a, ena_b, trk, f1, f2, reset_n_i} = '0;
    seed = 73;
    tick(5);
    reset_n_i <= 1'b1;
    ena_a <= 1'b1;
    ena_b <= 1'b1;
    tick(4);
    note(M_P1 | M_P2, 10'h030);
    tick(60);
    note(M_P1 | M_P2 | M_R, 10'h000);
    len = 1 + ($unsigned($random(seed)) % 3);
    f1 <= 4'h8;
    tick(len);
    f1 <= 4'h0;
    tick(12);
    note(M_P1, 10'h000);
    f1 <= 4'h8;
    tick(30);
    note(M_P1 | M_P2, 10'h020);
    f1 <= 4'h2;
    tick(40);
    note(M_G1 | M_P1 | M_O1 | M_L1, 10'h122);
    f1 <= 4'h0;
    tick(30);
    note(M_O1 | M_L1 | M_P1, 10'h000);
    per(1);
    f1 <= 4'h1;
    per(3);
    note(M_G1 | M_L1, 10'h000);
    f1 <= 4'h0;
    per(2);
    note(M_G1 | M_L1, 10'h200);
    f1 <= 4'h1;
    per(2);
    note(M_L1, 10'h000);
    per(4);
    note(M_G1 | M_P1 | M_L1 | M_L2, 10'h028);
    f1 <= 4'h0;
    ena_a <= 1'b0;
    tick(20);
    note(M_L1, 10'h008);
    clear_both();
    note(M_L1, 10'h000);
    per(1);
    f1 <= 4'h1;
    per(1);
    f1 <= 4'h0;
    per(16 + ($unsigned($random(seed)) % 4));
    f1 <= 4'h1;
    per(1);
    f1 <= 4'h0;
    per(3);
    note(M_L1, 10'h000);
    f1 <= 4'h4;
    tick(2);
    f1 <= 4'h0;
    tick(8);
    note(M_G1 | M_L1 | M_L2, 10'h008);
    clear_both();
    f2 <= 4'h4;
    tick(2);
    f2 <= 4'h0;
    tick(8);
    note(M_L1 | M_L2 | M_G2, 10'h004);
    clear_both();
    reset_n_i <= 1'b0;
    trk <= 1'b1;
    tick(5);
    reset_n_i <= 1'b1;
    tick(40);
    f2 <= 4'h6;
    tick(10);
    note(M_L2 | M_P2 | M_R, 10'h001);
    @(negedge clock_i);
    check({9'h000, ovr_b}, 10'h000);
    tick(1);
    f2 <= 4'h0;
    f1 <= 4'h4;
    tick(2);
    f1 <= 4'h0;
    tick(8);
    note(M_L1 | M_P1, 10'h028);
    tick(3);
    finish_test();
  end
endmodule
`default_nettype wire
